// ===== isp_pkg.sv
package isp_pkg;
	localparam int ADDR_W = 12;
	localparam logic [7:0] KEY_FIRST = 8'h87;
	localparam logic [7:0] KEY_SECOND = 8'h59;
	localparam logic [7:0] IDX_PROG_CTRL = 8'hbf;
	localparam logic [7:0] IDX_KEY = 8'hc0;
	localparam logic [7:0] IDX_ADDR_HI = 8'hc4;
	localparam logic [7:0] IDX_ADDR_LO = 8'hc5;
	localparam logic [7:0] IDX_DATA = 8'hc6;
	localparam logic [7:0] IDX_ROM_CTRL = 8'hc7;
	localparam logic [7:0] IDX_STATUS = 8'hc8;
	localparam int PCR_ENABLE = 0;
	localparam int PCR_BOOTSEL = 1;
	localparam int PCR_AUX = 4;
	localparam int PCR_RUNBANK = 5;
	localparam int PCR_SWRST = 7;
	localparam logic [7:0] PCR_WRITE_MASK = 8'h9b;
	localparam logic [7:0] PCR_RESET = 8'h08;
	localparam int RC_BANK = 6;
	localparam int RC_OE = 5;
	localparam int RC_CE = 4;
	localparam logic [7:0] RC_WRITE_MASK = 8'h7f;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [3:0] CODE_READ = 4'h0;
	localparam logic [3:0] CODE_PROG = 4'h1;
	localparam logic [3:0] CODE_ERASE = 4'h2;
	localparam logic [15:0] LOADER_ADDR_MASK = 16'h0fff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {OP_NONE, OP_READ, OP_PROG, OP_ERASE} op_t;
	typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN} key_t;

	// Decode a control byte into a flash operation
	function automatic op_t decode_op(input logic [7:0] c);
		op_t r;
		r = OP_NONE;
		if (c[3:0] == CODE_ERASE && c[RC_OE] && !c[RC_CE]) begin
			r = OP_ERASE;
		end
		if (c[3:0] == CODE_PROG && c[RC_OE] && !c[RC_CE]) begin
			r = OP_PROG;
		end
		if (c[3:0] == CODE_READ && !c[RC_OE] && !c[RC_CE]) begin
			r = OP_READ;
		end
		return r;
	endfunction
endpackage

// ===== isp_flash_if.sv
`timescale 1ns/1ns
interface isp_flash_if;
	logic start;
	logic [7:0] ctrl;
	logic [7:0] addrHi;
	logic [7:0] addrLo;
	logic [7:0] wdata;
	logic busy;
	logic rdValid;
	logic [7:0] rdata;
	modport ctl(output start, ctrl, addrHi, addrLo, wdata,
		input busy, rdValid, rdata);
	modport seq(input start, ctrl, addrHi, addrLo, wdata,
		output busy, rdValid, rdata);
endinterface

// ===== flash_sequencer.sv
`timescale 1ns/1ns
module flash_sequencer (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	isp_flash_if.seq fl,
	output logic [15:0] flashAddr,
	output logic [7:0] flashWdata,
	output logic flashBankSel,
	output logic flashOutputEnable,
	output logic flashChipEnable,
	output logic [3:0] flashCode,
	output logic flashStart,
	input wire logic [7:0] flashRdata,
	input wire logic flashDone
);
	typedef enum logic {SQ_IDLE, SQ_RUN} seq_t;
	seq_t state_ff, nxt_state;
	isp_pkg::op_t op_ff, nxt_op;
	logic [15:0] addr_ff, nxt_addr;
	logic [7:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
	logic [7:0] ctrl_ff, nxt_ctrl;
	logic start_ff, nxt_start, rdValid_ff, nxt_rdValid;

	always_comb begin
		nxt_state = state_ff;
		nxt_op = op_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_rdata = rdata_ff;
		nxt_ctrl = ctrl_ff;
		nxt_start = 1'b0;
		nxt_rdValid = 1'b0;
		case (state_ff)
			SQ_IDLE: begin
				if (fl.start) begin
					nxt_op = isp_pkg::decode_op(fl.ctrl);
					nxt_ctrl = fl.ctrl;
					nxt_addr = {fl.addrHi, fl.addrLo};
					if (fl.ctrl[isp_pkg::RC_BANK]) begin
						nxt_addr = {fl.addrHi, fl.addrLo} &
							isp_pkg::LOADER_ADDR_MASK;
					end
					nxt_wdata = fl.wdata;
					if (isp_pkg::decode_op(fl.ctrl) != isp_pkg::OP_NONE) begin
						nxt_state = SQ_RUN;
						nxt_start = 1'b1;
					end
				end
			end
			SQ_RUN: begin
				if (flashDone) begin
					nxt_state = SQ_IDLE;
					if (op_ff == isp_pkg::OP_READ) begin
						nxt_rdata = flashRdata;
						nxt_rdValid = 1'b1;
					end
				end
			end
			default: nxt_state = SQ_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= SQ_IDLE;
			op_ff <= isp_pkg::OP_NONE;
			addr_ff <= 16'h0000;
			wdata_ff <= isp_pkg::BYTE_RESET;
			rdata_ff <= isp_pkg::BYTE_RESET;
			ctrl_ff <= isp_pkg::BYTE_RESET;
			start_ff <= 1'b0;
			rdValid_ff <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			op_ff <= nxt_op;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			rdata_ff <= nxt_rdata;
			ctrl_ff <= nxt_ctrl;
			start_ff <= nxt_start;
			rdValid_ff <= nxt_rdValid;
		end
	end

	assign flashAddr = addr_ff;
	assign flashWdata = wdata_ff;
	assign flashStart = start_ff;
	assign flashBankSel = ctrl_ff[isp_pkg::RC_BANK];
	assign flashOutputEnable = (state_ff == SQ_RUN) ?
		ctrl_ff[isp_pkg::RC_OE] : 1'b1;
	assign flashChipEnable = (state_ff == SQ_RUN) ?
		ctrl_ff[isp_pkg::RC_CE] : 1'b1;
	assign flashCode = ctrl_ff[3:0];
	assign fl.busy = (state_ff == SQ_RUN);
	assign fl.rdValid = rdValid_ff;
	assign fl.rdata = rdata_ff;
endmodule

// ===== isp_flash_access_control.sv
`timescale 1ns/1ns
module isp_flash_access_control (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cpuIdle,
	input wire logic cpuWake,
	output logic pcClear,
	output logic fetchFromLoader,
	output logic softwareReset,
	output logic auxRamEnable,
	output logic [15:0] flashAddr,
	output logic [7:0] flashWdata,
	output logic flashBankSel,
	output logic flashOutputEnable,
	output logic flashChipEnable,
	output logic [3:0] flashCode,
	output logic flashStart,
	input wire logic [7:0] flashRdata,
	input wire logic flashDone
);
	isp_flash_if fl();

	// Bus state
	logic awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld;
	logic [11:0] awAddr_ff, nxt_awAddr;
	logic [7:0] wData_ff, nxt_wData;
	logic wStrb_ff, nxt_wStrb;
	logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [7:0] rdata_ff, nxt_rdata;
	logic wrFire;

	// Core state
	isp_pkg::key_t key_ff, nxt_key;
	logic [7:0] pcr_ff, nxt_pcr, romCtrl_ff, nxt_romCtrl;
	logic [7:0] addrHi_ff, nxt_addrHi, addrLo_ff, nxt_addrLo;
	logic [7:0] data_ff, nxt_data;
	logic progMode_ff, nxt_progMode, opPending_ff, nxt_opPending;
	logic pcClear_ff, nxt_pcClear, software_reset_bit_ff, nxt_software_reset_bit;
	logic opStart;

	function automatic logic is_mapped(input logic [11:0] a);
		logic [7:0] i;
		i = a[9:2];
		return a[11:10] == 2'b00 &&
			(i == isp_pkg::IDX_PROG_CTRL || i == isp_pkg::IDX_KEY ||
			i == isp_pkg::IDX_ADDR_HI || i == isp_pkg::IDX_ADDR_LO ||
			i == isp_pkg::IDX_DATA || i == isp_pkg::IDX_ROM_CTRL ||
			i == isp_pkg::IDX_STATUS);
	endfunction

	function automatic logic [7:0] read_reg(input logic [11:0] a,
		input logic [7:0] pcr, input logic [7:0] rc,
		input logic [7:0] ah, input logic [7:0] al,
		input logic [7:0] d, input logic [7:0] st);
		logic [7:0] r;
		r = 8'h00;
		case (a[9:2])
			isp_pkg::IDX_PROG_CTRL: r = pcr;
			isp_pkg::IDX_ADDR_HI: r = ah;
			isp_pkg::IDX_ADDR_LO: r = al;
			isp_pkg::IDX_DATA: r = d;
			isp_pkg::IDX_ROM_CTRL: r = rc;
			isp_pkg::IDX_STATUS: r = st;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	logic [7:0] pcrView, statusView;
	always_comb begin
		pcrView = pcr_ff & isp_pkg::PCR_WRITE_MASK;
		pcrView[isp_pkg::PCR_RUNBANK] = progMode_ff;
		statusView = {4'h0, fl.busy, opPending_ff, progMode_ff,
			key_ff == isp_pkg::KEY_OPEN};
	end

	assign s_axi_awready = ce && !awHeld_ff && !bvalid_ff;
	assign s_axi_wready = ce && !wHeld_ff && !bvalid_ff;
	assign s_axi_arready = ce && !rvalid_ff;
	assign wrFire = awHeld_ff && wHeld_ff && !bvalid_ff;

	always_comb begin
		nxt_awHeld = awHeld_ff;
		nxt_awAddr = awAddr_ff;
		nxt_wHeld = wHeld_ff;
		nxt_wData = wData_ff;
		nxt_wStrb = wStrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_awHeld = 1'b1;
			nxt_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_wHeld = 1'b1;
			nxt_wData = s_axi_wdata[7:0];
			nxt_wStrb = s_axi_wstrb[0];
		end
		if (wrFire) begin
			nxt_awHeld = 1'b0;
			nxt_wHeld = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = is_mapped(awAddr_ff) ? isp_pkg::RESP_OKAY :
				isp_pkg::RESP_SLVERR;
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = is_mapped(s_axi_araddr) ? isp_pkg::RESP_OKAY :
				isp_pkg::RESP_SLVERR;
			nxt_rdata = read_reg(s_axi_araddr, pcrView, romCtrl_ff,
				addrHi_ff, addrLo_ff, data_ff, statusView);
		end
		if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			awHeld_ff <= 1'b0;
			awAddr_ff <= 12'h000;
			wHeld_ff <= 1'b0;
			wData_ff <= isp_pkg::BYTE_RESET;
			wStrb_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= isp_pkg::RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff <= isp_pkg::RESP_OKAY;
			rdata_ff <= isp_pkg::BYTE_RESET;
		end else if (ce) begin
			awHeld_ff <= nxt_awHeld;
			awAddr_ff <= nxt_awAddr;
			wHeld_ff <= nxt_wHeld;
			wData_ff <= nxt_wData;
			wStrb_ff <= nxt_wStrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = {24'h000000, rdata_ff};

	always_comb begin
		nxt_key = key_ff;
		nxt_pcr = pcr_ff;
		nxt_romCtrl = romCtrl_ff;
		nxt_addrHi = addrHi_ff;
		nxt_addrLo = addrLo_ff;
		nxt_data = data_ff;
		nxt_progMode = progMode_ff;
		nxt_opPending = opPending_ff;
		nxt_pcClear = 1'b0;
		nxt_software_reset_bit = 1'b0;
		opStart = 1'b0;
		if (opPending_ff && cpuIdle && !fl.busy) begin
			opStart = 1'b1;
			nxt_opPending = 1'b0;
		end
		// New control write wins over launch
		if (wrFire && wStrb_ff && is_mapped(awAddr_ff)) begin
			case (awAddr_ff[9:2])
				isp_pkg::IDX_KEY: begin
					if (wData_ff == isp_pkg::KEY_FIRST) begin
						nxt_key = isp_pkg::KEY_HALF;
					end else if (wData_ff == isp_pkg::KEY_SECOND &&
						key_ff == isp_pkg::KEY_HALF) begin
						nxt_key = isp_pkg::KEY_OPEN;
					end else begin
						nxt_key = isp_pkg::KEY_LOCKED;
					end
				end
				isp_pkg::IDX_PROG_CTRL: begin
					if (key_ff == isp_pkg::KEY_OPEN) begin
						// Aux RAM and fixed bit stored
						nxt_pcr = wData_ff & isp_pkg::PCR_WRITE_MASK;
						nxt_software_reset_bit = wData_ff[isp_pkg::PCR_ENABLE] &&
							wData_ff[isp_pkg::PCR_BOOTSEL] &&
							wData_ff[isp_pkg::PCR_SWRST];
					end
				end
				isp_pkg::IDX_ROM_CTRL: begin
					nxt_romCtrl = wData_ff & isp_pkg::RC_WRITE_MASK;
					nxt_opPending = progMode_ff;
				end
				isp_pkg::IDX_ADDR_HI: nxt_addrHi = wData_ff;
				isp_pkg::IDX_ADDR_LO: nxt_addrLo = wData_ff;
				isp_pkg::IDX_DATA: nxt_data = wData_ff;
				default: nxt_key = key_ff;
			endcase
		end
		// Read result captured over software write
		if (fl.rdValid) begin
			nxt_data = fl.rdata;
		end
		// Enter at wake, not at write
		if (pcr_ff[isp_pkg::PCR_ENABLE] && !progMode_ff &&
			cpuIdle && cpuWake) begin
			nxt_progMode = 1'b1;
			nxt_pcClear = 1'b1;
		end
		if (software_reset_bit_ff) begin
			nxt_key = isp_pkg::KEY_LOCKED;
			nxt_pcr = isp_pkg::PCR_RESET;
			nxt_romCtrl = isp_pkg::BYTE_RESET;
			nxt_addrHi = isp_pkg::BYTE_RESET;
			nxt_addrLo = isp_pkg::BYTE_RESET;
			nxt_data = isp_pkg::BYTE_RESET;
			nxt_progMode = 1'b0;
			nxt_opPending = 1'b0;
			nxt_pcClear = 1'b0;
			opStart = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			key_ff <= isp_pkg::KEY_LOCKED;
			pcr_ff <= isp_pkg::PCR_RESET;
			romCtrl_ff <= isp_pkg::BYTE_RESET;
			addrHi_ff <= isp_pkg::BYTE_RESET;
			addrLo_ff <= isp_pkg::BYTE_RESET;
			data_ff <= isp_pkg::BYTE_RESET;
			progMode_ff <= 1'b0;
			opPending_ff <= 1'b0;
			pcClear_ff <= 1'b0;
			software_reset_bit_ff <= 1'b0;
		end else if (ce) begin
			key_ff <= nxt_key;
			pcr_ff <= nxt_pcr;
			romCtrl_ff <= nxt_romCtrl;
			addrHi_ff <= nxt_addrHi;
			addrLo_ff <= nxt_addrLo;
			data_ff <= nxt_data;
			progMode_ff <= nxt_progMode;
			opPending_ff <= nxt_opPending;
			pcClear_ff <= nxt_pcClear;
			software_reset_bit_ff <= nxt_software_reset_bit;
		end
	end

	assign fl.start = opStart;
	assign fl.ctrl = romCtrl_ff;
	assign fl.addrHi = addrHi_ff;
	assign fl.addrLo = addrLo_ff;
	assign fl.wdata = data_ff;

	assign fetchFromLoader = progMode_ff;
	assign pcClear = pcClear_ff;
	// Reset pulse returns to application bank
	assign softwareReset = software_reset_bit_ff;
	assign auxRamEnable = pcr_ff[isp_pkg::PCR_AUX];

	flash_sequencer seq (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.ce(ce),
		.fl(fl),
		.flashAddr(flashAddr),
		.flashWdata(flashWdata),
		.flashBankSel(flashBankSel),
		.flashOutputEnable(flashOutputEnable),
		.flashChipEnable(flashChipEnable),
		.flashCode(flashCode),
		.flashStart(flashStart),
		.flashRdata(flashRdata),
		.flashDone(flashDone)
	);
endmodule

// ===== isp_flash_monitor.sv
`timescale 1ns/1ns
module isp_flash_monitor (
	input logic sys_clk,
	input logic nrst,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic cpuIdle,
	input logic cpuWake,
	input logic pcClear,
	input logic fetchFromLoader,
	input logic softwareReset,
	input logic auxRamEnable,
	input logic [15:0] flashAddr,
	input logic flashBankSel,
	input logic flashOutputEnable,
	input logic flashChipEnable,
	input logic [3:0] flashCode,
	input logic flashStart,
	input logic flashDone
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	sequence s_legal;
		(flashCode == 4'h2 && flashOutputEnable && !flashChipEnable) ||
		(flashCode == 4'h1 && flashOutputEnable && !flashChipEnable) ||
		(flashCode == 4'h0 && !flashOutputEnable && !flashChipEnable);
	endsequence
	sequence s_entry;
		pcClear && fetchFromLoader;
	endsequence
	sequence s_released;
		flashStart || (flashOutputEnable && flashChipEnable);
	endsequence
	sequence s_cleared;
		!fetchFromLoader && !auxRamEnable;
	endsequence
	a_start_legal: assert property (flashStart |-> s_legal)
		else $error("illegal flash operation started");
	a_start_idle: assert property (flashStart |-> $past(cpuIdle))
		else $error("flash operation started outside idle");
	a_start_mode: assert property (flashStart |-> fetchFromLoader)
		else $error("flash operation outside programming mode");
	a_loader_mask: assert property (flashStart && flashBankSel |->
		flashAddr[15:12] == 4'h0)
		else $error("loader bank address above 4K");
	a_entry_pc: assert property ($rose(fetchFromLoader) |-> s_entry)
		else $error("programming entry without counter clear");
	a_pc_wake: assert property (pcClear |-> $past(cpuIdle && cpuWake))
		else $error("counter clear without wake from idle");
	a_swrst_pulse: assert property (softwareReset |=> !softwareReset)
		else $error("software reset longer than one cycle");
	a_swrst_clears: assert property (softwareReset |-> ##2 s_cleared)
		else $error("software reset left state set");
	a_done_release: assert property (flashDone |=> s_released)
		else $error("flash enables still active after done");
	a_rdata_hold: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed after transfer");
endmodule
bind isp_flash_access_control isp_flash_monitor mon_u (.sys_clk, .nrst,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cpuIdle, .cpuWake,
	.pcClear, .fetchFromLoader, .softwareReset, .auxRamEnable, .flashAddr,
	.flashBankSel, .flashOutputEnable, .flashChipEnable, .flashCode,
	.flashStart, .flashDone);

// ===== flash_model.sv
`timescale 1ns/1ns
module flash_model (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic slow,
	input wire logic flashStart,
	input wire logic [15:0] flashAddr,
	input wire logic [7:0] flashWdata,
	input wire logic [3:0] flashCode,
	output logic [7:0] flashRdata,
	output logic flashDone
);
	logic run_ff;
	logic [3:0] cnt_ff;
	logic [7:0] byte_ff;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			run_ff <= 1'b0;
			cnt_ff <= 4'h0;
			byte_ff <= 8'h00;
		end else if (flashStart) begin
			run_ff <= 1'b1;
			cnt_ff <= slow ? 4'h6 : 4'h0;
			byte_ff <= flashCode == 4'h0 ? flashAddr[7:0] ^ 8'ha5 : flashWdata;
		end else if (run_ff && cnt_ff != 4'h0) begin
			cnt_ff <= cnt_ff - 4'h1;
		end else begin
			run_ff <= 1'b0;
		end
	end
	assign flashDone = run_ff && cnt_ff == 4'h0;
	assign flashRdata = flashDone ? byte_ff : ~byte_ff ^ {4'h0, cnt_ff};
endmodule

// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top;
	localparam logic [11:0] A_PCR = 12'h2fc, A_KEY = 12'h300;
	localparam logic [11:0] A_AH = 12'h310, A_AL = 12'h314;
	localparam logic [11:0] A_DAT = 12'h318, A_RC = 12'h31c;
	localparam logic [11:0] A_ST = 12'h320, A_BAD = 12'h004;
	logic sys_clk, nrst, ce, cpuIdle, cpuWake, slow;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, pcClear, fetchFromLoader;
	logic softwareReset, auxRamEnable, flashBankSel, flashOutputEnable;
	logic flashChipEnable, flashStart, flashDone;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb, flashCode;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [15:0] flashAddr, sAddr, cA;
	logic [7:0] flashWdata, flashRdata, sWd, cC, cD;
	logic [6:0] sCtl;
	logic [7:0] ctl [6] = '{8'h22, 8'h21, 8'h00, 8'h62, 8'h61, 8'h40};
	int fails, num_checks, cyc, nStart, nReset, nPc, n0;
	isp_flash_access_control dut_u (.sys_clk, .nrst, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpuIdle,
		.cpuWake, .pcClear, .fetchFromLoader, .softwareReset, .auxRamEnable,
		.flashAddr, .flashWdata, .flashBankSel, .flashOutputEnable,
		.flashChipEnable, .flashCode, .flashStart, .flashRdata, .flashDone);
	flash_model fm_u (.sys_clk, .nrst, .slow, .flashStart, .flashAddr,
		.flashWdata, .flashCode, .flashRdata, .flashDone);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) begin
		if (flashStart === 1'b1) begin
			nStart++;
			sAddr = flashAddr;
			sWd = flashWdata;
			sCtl = {flashBankSel, flashOutputEnable, flashChipEnable, flashCode};
		end
		if (softwareReset === 1'b1)
			nReset++;
		if (pcClear === 1'b1)
			nPc++;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic pa, pw, gb;
		@(posedge sys_clk);
		pa = 1'b1;
		pw = 1'b1;
		gb = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!gb) begin
			@(negedge sys_clk);
			pa = pa && s_axi_awready !== 1'b1;
			pw = pw && s_axi_wready !== 1'b1;
			gb = s_axi_bvalid === 1'b1;
			resp = s_axi_bresp;
			@(posedge sys_clk);
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
			s_axi_bready <= !gb;
		end
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		logic pa, gr;
		@(posedge sys_clk);
		pa = 1'b1;
		gr = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!gr) begin
			@(negedge sys_clk);
			pa = pa && s_axi_arready !== 1'b1;
			gr = s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge sys_clk);
			s_axi_arvalid <= pa;
			s_axi_rready <= !gr;
		end
	endtask
	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		logic [31:0] r;
		rd(a, r);
		chk(r, {24'h0, e});
	endtask
	task automatic unlock();
		wr(A_KEY, 8'h87);
		wr(A_KEY, 8'h59);
	endtask
	task automatic op_arm(input logic [7:0] c, input logic [15:0] a,
		input logic [7:0] d);
		cC = c;
		cA = a;
		cD = d;
		wr(A_AH, a[15:8]);
		wr(A_AL, a[7:0]);
		wr(A_DAT, d);
		n0 = nStart;
		wr(A_RC, c);
	endtask
	task automatic op_end();
		int k;
		k = 0;
		while (nStart == n0 && k < 60) begin
			@(posedge sys_clk);
			k++;
		end
		chk(nStart, n0 + 1);
		chk(sAddr, cC[6] ? cA & 16'h0fff : cA);
		chk(sCtl, cC[6:0]);
		if (cC[3:0] == 4'h1)
			chk(sWd, cD);
		k = 0;
		do begin
			rd(A_ST, v);
			k++;
		end while (v[3:2] !== 2'b00 && k < 30);
		chk(v[3:2], 2'b00);
		if (cC[3:0] == 4'h0)
			rchk(A_DAT, cA[7:0] ^ 8'ha5);
	endtask
	initial begin
		{nrst, cpuIdle, cpuWake, slow, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		ce = 1'b1;
		s_axi_wstrb = 4'hf;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		rchk(A_PCR, 8'h08);
		chk(fetchFromLoader, 1'b0);
		wr(A_PCR, 8'h11);
		rchk(A_PCR, 8'h08);
		unlock();
		wr(A_PCR, 8'h19);
		rchk(A_PCR, 8'h19);
		chk(auxRamEnable, 1'b1);
		chk(fetchFromLoader, 1'b0);
		wr(A_KEY, 8'h00);
		wr(A_PCR, 8'h09);
		rchk(A_PCR, 8'h19);
		wr(A_KEY, 8'h59);
		wr(A_KEY, 8'h87);
		wr(A_PCR, 8'h09);
		rchk(A_PCR, 8'h19);
		rd(A_BAD, v);
		chk(resp, 2'h2);
		wr(A_BAD, 8'hff);
		chk(resp, 2'h2);
		cpuIdle <= 1'b1;
		cpuWake <= 1'b1;
		@(posedge sys_clk);
		cpuWake <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(nPc, 1);
		chk(fetchFromLoader, 1'b1);
		rchk(A_PCR, 8'h39);
		for (int i = 0; i < 6; i++) begin
			slow <= i[0];
			op_arm(ctl[i], {8'hfa, 8'h30 + i[7:0]}, 8'h5c + i[7:0]);
			op_end();
		end
		cpuIdle <= 1'b0;
		op_arm(8'h00, 16'h1234, 8'h00);
		repeat (10) @(posedge sys_clk);
		chk(nStart, n0);
		cpuIdle <= 1'b1;
		op_end();
		op_arm(8'h23, 16'h0042, 8'h00);
		repeat (10) @(posedge sys_clk);
		chk(nStart, n0);
		unlock();
		wr(A_PCR | 12'h400, 8'h83);
		chk(resp, 2'h2);
		chk(nReset, 0);
		wr(A_PCR, 8'h83);
		repeat (3) @(posedge sys_clk);
		chk(nReset, 1);
		chk(fetchFromLoader, 1'b0);
		rchk(A_PCR, 8'h08);
		wr(A_PCR, 8'h19);
		rchk(A_PCR, 8'h08);
		print_verdict();
	end
endmodule
